// ---- pkg/iso_tx_regs.vh ----
// Register offsets, field positions, reset values and timing counts for the isochronous transmitter.
// What this block does
// R1: Phase flag low on start/stop, high otherwise.
// R2: Fill flag set at stop end if unloaded.
// R3: Send fill character repeatedly while nothing loaded.
// R4: New character follows fill with no gap.
// R5: Exactly one start and one stop element.
// R6: Control word selects mode, length, parity; the mode field is stored but not used.
// R7: Chip off masks controlled inputs.
// R8: Chip off floats controlled outputs; line stays.
// R9: Transfer hold to shift on CTS and idle.
// R10: CTS low finishes character, then holds mark.
// R11: Isochronous framing otherwise like synchronous mode.
// R12: LSB first, one bit per period, idle mark.
`ifndef ISO_TX_REGS_VH
`define ISO_TX_REGS_VH

// ****************************************************************
// Wishbone register offsets (byte addresses).
// ****************************************************************
`define REG_HOLD        8'h00
`define REG_FILL        8'h04
`define REG_FORMAT      8'h08
`define REG_STATUS      8'h0C
`define REG_IRQ_STATUS  8'h10
`define REG_IRQ_ENABLE  8'h14
`define REG_IRQ_CLEAR   8'h18
`define REG_CONTROL     8'h1C

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define FMT_PARITY_POL  0
`define FMT_PARITY_OFF  1
`define FMT_LEN_LO      2
`define FMT_FRAME_LO    4
`define FMT_RESET       6'h3C
`define CTL_FILL_CLEAR  0
`define CTL_MASTER_CLR  1
`define IRQ_HOLD_EMPTY  0
`define IRQ_FILL_PEND   1
`define BIT_DIV_RESET   16'h0009

`endif

// ---- verilog/iso_tx.v ----
// Isochronous serial transmitter with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "iso_tx_regs.vh"

module iso_tx #(
  parameter DIV_W = 16
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        cts,
  input  wire        chip_off,
  output reg         serial_out,
  output reg         char_phase_flag,
  output reg         fill_pending_flag,
  output reg         fill_pending_oe_n,
  output reg         hold_empty_flag,
  output reg         hold_empty_oe_n,
  output reg         irq
);

  // ****************************************************************
  // State encodings for the shifter.
  // ****************************************************************
  localparam [2:0] ST_IDLE   = 3'h0;  // Line at mark, nothing in flight.
  localparam [2:0] ST_START  = 3'h1;  // Start bit on the line.
  localparam [2:0] ST_DATA   = 3'h2;  // Data bits on the line.
  localparam [2:0] ST_PARITY = 3'h3;  // Parity bit on the line.
  localparam [2:0] ST_STOP   = 3'h4;  // Stop element on the line.

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  reg  [1:0] cts_sync_q;              // Two-stage CTS synchroniser.
  reg  [1:0] off_sync_q;              // Two-stage chip_off synchroniser.
  wire       cts_s = cts_sync_q[1];   // Synchronised clear-to-send.
  wire       off_s = off_sync_q[1];   // Synchronised chip disable.

  // Both pins come from outside the clock domain; only stage two is read.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_sync_q <= 2'h0;
      off_sync_q <= 2'h0;
    end else begin
      cts_sync_q <= {cts_sync_q[0], cts};
      off_sync_q <= {off_sync_q[0], chip_off};
    end
  end

  // ****************************************************************
  // Register file and Wishbone slave.
  // ****************************************************************
  reg  [7:0]       hold_q;            // Transmitter holding register.
  reg              hold_full_q;       // Holding register has a character.
  reg  [7:0]       fill_q;            // Fill character.
  reg  [5:0]       format_q;          // Character format control word.
  reg  [DIV_W-1:0] bit_div_q;         // Bit period divider value minus one.
  reg  [1:0]       irq_stat_q;        // Sticky event bits.
  reg  [1:0]       irq_en_q;          // Interrupt enables.
  reg              fill_flag_q;       // Fill pending state.
  reg              master_clear;      // Software master clear pulse.
  reg              fill_flag_clear;   // Software fill flag clear pulse.
  wire             wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;  // New access, at most one every two cycles.
  wire             wb_wr  = wb_req & wb_we_i & wb_sel_i[0];   // Low byte write.
  wire             gate   = ~off_s;                           // Inputs masked while chip is off.

  // Events reported from the shifter.
  reg              ev_hold_empty;     // Holding register drained into shift.
  reg              ev_fill_pend;      // Fill flag just raised.
  reg              take_hold;         // Shifter takes the holding register this cycle.
  reg  [2:0]       state_q;           // Shifter state, also read back as the busy bit.
  reg  [31:0]      wb_dat_o_d;        // Next read data.

  // Read mux follows the offset decode; unmapped reads give zero.
  always @* begin
    if (wb_adr_i == `REG_FORMAT)
      wb_dat_o_d = {26'h0, format_q};
    else if (wb_adr_i == `REG_STATUS)
      wb_dat_o_d = {28'h0, ~cts_s, fill_flag_q, ~hold_full_q, state_q != ST_IDLE};
    else if (wb_adr_i == `REG_IRQ_STATUS)
      wb_dat_o_d = {30'h0, irq_stat_q};
    else if (wb_adr_i == `REG_IRQ_ENABLE)
      wb_dat_o_d = {30'h0, irq_en_q};
    else if (wb_adr_i == `REG_CONTROL)
      wb_dat_o_d = {{(32-DIV_W){1'b0}}, bit_div_q};
    else
      wb_dat_o_d = 32'h0;
  end

  // Single-cycle answer: ack one edge after the request, dropped the next.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0;
      hold_q          <= 8'h0;
      hold_full_q     <= 1'b0;
      fill_q          <= 8'h0;
      format_q        <= `FMT_RESET;
      bit_div_q       <= `BIT_DIV_RESET;
      irq_en_q        <= 2'h0;
      master_clear    <= 1'b0;
      fill_flag_clear <= 1'b0;
    end else begin
      wb_ack_o        <= wb_req;
      wb_dat_o        <= wb_dat_o_d;
      master_clear    <= 1'b0;
      fill_flag_clear <= 1'b0;
      // R9: hold drains on take
      if (take_hold)
        hold_full_q <= 1'b0;
      // R7: loads gated off
      if (wb_wr && gate) begin
        if (wb_adr_i == `REG_HOLD) begin
          hold_q      <= wb_dat_i[7:0];
          hold_full_q <= 1'b1;
        end else if (wb_adr_i == `REG_FILL)
          fill_q <= wb_dat_i[7:0];
        else if (wb_adr_i == `REG_FORMAT)
          format_q <= wb_dat_i[5:0];
        else if (wb_adr_i == `REG_IRQ_ENABLE)
          irq_en_q <= wb_dat_i[1:0];
        else if (wb_adr_i == `REG_CONTROL) begin
          fill_flag_clear <= wb_dat_i[`CTL_FILL_CLEAR];
          master_clear    <= wb_dat_i[`CTL_MASTER_CLR];
        end
      end
      // The divider is a link setting, written even while chip is off.
      if (wb_req && wb_we_i && wb_adr_i == `REG_CONTROL && wb_sel_i[3:2] != 2'h0)
        bit_div_q <= wb_dat_i[16 +: DIV_W];
      if (master_clear) begin
        hold_full_q <= 1'b0;
        format_q    <= `FMT_RESET;
      end
    end
  end

  // Sticky interrupt bits: an event in the same cycle as a clear wins.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= 2'h0;
      irq        <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == `REG_IRQ_CLEAR)
        irq_stat_q <= (irq_stat_q & ~wb_dat_i[1:0]) | {ev_fill_pend, ev_hold_empty};
      else
        irq_stat_q <= irq_stat_q | {ev_fill_pend, ev_hold_empty};
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ****************************************************************
  // Bit-rate divider: one enable pulse per bit period.
  // ****************************************************************
  reg  [DIV_W-1:0] div_q;             // Down counter.
  wire             bit_tick = (div_q == {DIV_W{1'b0}});  // End of a bit period.
  wire             half_tick = (div_q == (bit_div_q >> 1)); // Centre of a bit.

  // R12: one bit per period
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      div_q <= {DIV_W{1'b0}};
    else if (bit_tick)
      div_q <= bit_div_q;
    else
      div_q <= div_q - {{(DIV_W-1){1'b0}}, 1'b1};
  end

  // ****************************************************************
  // Shifter.
  // ****************************************************************
  reg  [7:0] shift_q;                 // Shift register.
  reg  [2:0] cnt_q;                   // Data bits left minus one.
  reg        par_q;                   // Running parity.
  reg        seen_q;                  // Character loaded before stop centre.
  reg        filling_q;               // Fill sequence is active.
  // R11: contiguous framing always used
  wire [2:0] len_m1 = {1'b1, format_q[`FMT_LEN_LO +: 2]} - 3'h4 + 3'h4; // 4..7 means 5..8 bits.
  wire       par_off = format_q[`FMT_PARITY_OFF];
  wire       par_even = format_q[`FMT_PARITY_POL];

  // Sends frames: start, data LSB first, optional parity, one stop.
  always @* begin
    take_hold = 1'b0;
    if (bit_tick && cts_s && hold_full_q && (state_q == ST_IDLE || state_q == ST_STOP))
      take_hold = 1'b1;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q       <= ST_IDLE;
      shift_q       <= 8'h0;
      cnt_q         <= 3'h0;
      par_q         <= 1'b0;
      seen_q        <= 1'b0;
      filling_q     <= 1'b0;
      fill_flag_q   <= 1'b0;
      ev_hold_empty <= 1'b0;
      ev_fill_pend  <= 1'b0;
      serial_out    <= 1'b1;
      char_phase_flag <= 1'b0;
    end else begin
      ev_hold_empty <= 1'b0;
      ev_fill_pend  <= 1'b0;
      if (fill_flag_clear)
        fill_flag_q <= 1'b0;
      if (master_clear) begin
        state_q     <= ST_IDLE;
        filling_q   <= 1'b0;
        fill_flag_q <= 1'b0;
        serial_out  <= 1'b1;
        char_phase_flag <= 1'b0;
      end else begin
        // R2: sample at stop centre
        if (state_q == ST_STOP && half_tick)
          seen_q <= hold_full_q;
        if (bit_tick) begin
          case (state_q)
            ST_IDLE, ST_STOP: begin
              // R9: transfer on CTS and idle
              if (take_hold) begin
                shift_q       <= hold_q;
                // R4: fill ends, char follows
                filling_q     <= 1'b0;
                ev_hold_empty <= 1'b1;
                state_q       <= ST_START;
                // R5: one start bit
                serial_out    <= 1'b0;
              end else if (cts_s && (filling_q || (state_q == ST_STOP && !seen_q))) begin
                // R3: resend fill character
                shift_q    <= fill_q;
                filling_q  <= 1'b1;
                state_q    <= ST_START;
                serial_out <= 1'b0;
                // R2: flag at stop end
                if (state_q == ST_STOP && !seen_q && !fill_flag_q) begin
                  fill_flag_q  <= 1'b1;
                  ev_fill_pend <= 1'b1;
                end
              end else begin
                // R10: hold mark until CTS
                state_q    <= ST_IDLE;
                serial_out <= 1'b1;
              end
              // R1: low on start/stop
              char_phase_flag <= 1'b0;
            end
            ST_START: begin
              // R12: LSB first
              serial_out      <= shift_q[0];
              shift_q         <= {1'b0, shift_q[7:1]};
              par_q           <= shift_q[0];
              cnt_q           <= len_m1;
              state_q         <= ST_DATA;
              char_phase_flag <= 1'b1;
            end
            ST_DATA: begin
              cnt_q <= cnt_q - 3'h1;
              if (cnt_q != 3'h0) begin
                serial_out <= shift_q[0];
                shift_q    <= {1'b0, shift_q[7:1]};
                par_q      <= par_q ^ shift_q[0];
              end else if (!par_off) begin
                // R6: even or odd parity
                serial_out <= par_even ? par_q : ~par_q;
                state_q    <= ST_PARITY;
              end else begin
                serial_out      <= 1'b1;
                state_q         <= ST_STOP;
                char_phase_flag <= 1'b0;
              end
            end
            ST_PARITY: begin
              // R5: single stop element
              serial_out      <= 1'b1;
              state_q         <= ST_STOP;
              char_phase_flag <= 1'b0;
            end
            default: begin
              state_q    <= ST_IDLE;
              serial_out <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Chip-off controlled status outputs.
  // ****************************************************************
  // R8: float controlled outputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_empty_flag   <= 1'b1;
      fill_pending_flag <= 1'b0;
      hold_empty_oe_n   <= 1'b0;
      fill_pending_oe_n <= 1'b0;
    end else begin
      hold_empty_flag   <= ~hold_full_q;
      fill_pending_flag <= fill_flag_q;
      hold_empty_oe_n   <= off_s;
      fill_pending_oe_n <= off_s;
    end
  end

endmodule // iso_tx

// ---- dv/iso_tx_props.sv ----
// Concurrent checks on the transmitter pins.
`timescale 1ns/1ps
module iso_tx_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_off,
  input wire logic serial_out,
  input wire logic char_phase_flag,
  input wire logic fill_pending_flag,
  input wire logic fill_pending_oe_n,
  input wire logic hold_empty_flag,
  input wire logic hold_empty_oe_n
);
  // *****
  // Framing, flags and float control.
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_start_before_data: assert property ($rose(char_phase_flag) |-> !$past(serial_out))
    else $error("data phase began without a start bit");
  chk_stop_is_mark: assert property ($fell(char_phase_flag) |-> serial_out)
    else $error("data phase ended on a space");
  chk_bit_holds: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
    else $error("line changed inside a bit period");
  chk_fill_starts: assert property ($rose(fill_pending_flag) |-> ##[0:2] !serial_out)
    else $error("fill flag rose without a fill frame");
  chk_hold_starts: assert property ($rose(hold_empty_flag) |-> ##[0:2] !serial_out)
    else $error("holding register drained without a start bit");
  chk_float_off: assert property (chip_off [*5] |-> fill_pending_oe_n && hold_empty_oe_n)
    else $error("flags driven while chip is off");
  chk_drive_on: assert property (!chip_off [*5] |-> !fill_pending_oe_n && !hold_empty_oe_n)
    else $error("flags floating while chip is on");
  chk_idle_mark: assert property ($rose(reset_n) |-> serial_out)
    else $error("line not at mark after reset");
  cov_fill: cover property ($rose(fill_pending_flag));
  cov_float: cover property (chip_off [*5]);
  cov_phase: cover property ($fell(char_phase_flag));
endmodule // iso_tx_props
bind iso_tx iso_tx_props iso_tx_props_i (.clk(clk), .reset_n(reset_n), .chip_off(chip_off), .serial_out(serial_out),
  .char_phase_flag(char_phase_flag), .fill_pending_flag(fill_pending_flag), .fill_pending_oe_n(fill_pending_oe_n),
  .hold_empty_flag(hold_empty_flag), .hold_empty_oe_n(hold_empty_oe_n));

// ---- dv/line_receiver.sv ----
// Line receiver model: frames the serial output and drives clear-to-send.
`timescale 1ns/1ps
module line_receiver #(
  parameter BIT = 10
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        serial_out,
  input  wire logic        stall,
  input  wire logic [3:0]  nbits,
  output logic             cts,
  output logic             done,
  output logic [11:0]      frame,
  output logic [7:0]       gap
);
  // *****
  // Receiver state.
  // *****
  logic       busy_q;  // Inside a frame.
  logic [7:0] cnt_q;   // Position within the bit.
  logic [3:0] idx_q;   // Bit index, start bit is zero.
  logic [7:0] idle_q;  // Idle edges since the last stop centre.
  assign cts = !stall;
  // Samples at bit centre; the gap before a frame shows contiguity.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      idle_q <= 8'h00;
      done <= 1'b0;
      gap <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy_q) begin
        idle_q <= idle_q + 8'h01;
        // A space on an idle line opens a frame.
        if (!serial_out) begin
          busy_q <= 1'b1;
          cnt_q <= 8'h01;
          idx_q <= 4'h0;
          frame <= 12'h000;
          gap <= idle_q;
        end
      end else begin
        cnt_q <= (cnt_q == BIT - 1) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == BIT / 2) begin
          frame[idx_q] <= serial_out;
          idx_q <= idx_q + 4'h1;
          // The stop sample closes the frame.
          if (idx_q == nbits - 4'h1) begin
            busy_q <= 1'b0;
            done <= 1'b1;
            idle_q <= 8'h00;
          end
        end
      end
    end
  end
endmodule // line_receiver

// ---- dv/iso_tx_bench.sv ----
// Self-checking bench for the isochronous transmitter.
`timescale 1ns/1ps
`include "iso_tx_regs.vh"
module iso_tx_bench;
  // *****
  // Stimulus, observation and counters.
  // *****
  logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, chip_off = 0, stall = 0;
  logic [7:0] adr = 0, ch;
  logic [31:0] dat = 0, rdata, wb_dat_o;
  logic [3:0] nbits = 4'hA;
  logic wb_ack_o, cts, serial_out, char_phase_flag, fill_pending_flag, fill_pending_oe_n;
  logic hold_empty_flag, hold_empty_oe_n, irq, done;
  logic [11:0] frame, e;
  logic [7:0] gap;
  int error_cnt = 0, compares = 0, cycles = 0, n;
  // Rows: every length and parity setting of the contiguous-framing control code.
  logic [5:0] fmts [12] = '{6'h30, 6'h31, 6'h32, 6'h34, 6'h35, 6'h37, 6'h38, 6'h39, 6'h3A, 6'h3C, 6'h3D, 6'h3F};
  iso_tx iso_tx_i (.clk(clk), .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cts(cts), .chip_off(chip_off),
    .serial_out(serial_out), .char_phase_flag(char_phase_flag), .fill_pending_flag(fill_pending_flag),
    .fill_pending_oe_n(fill_pending_oe_n), .hold_empty_flag(hold_empty_flag), .hold_empty_oe_n(hold_empty_oe_n),
    .irq(irq));
  line_receiver line_receiver_i (.clk(clk), .reset_n(reset_n), .serial_out(serial_out), .stall(stall),
    .nbits(nbits), .cts(cts), .done(done), .frame(frame), .gap(gap));
  always #20 clk = ~clk;
  // Whole run is near 5000 cycles; the ceiling leaves ample room.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single cycle; held until ack is sampled, released after.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin @(posedge clk); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    rdata = wb_dat_o;
    cyc <= 0;
    stb <= 0;
    if (k >= 20) chk("ack", 1, 0);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic waitf();
    int k = 0;
    do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 400);
  endtask
  // Expected frame: start, data low bit first, parity if enabled, stop.
  function automatic logic [11:0] frm(input logic [5:0] f, input logic [7:0] c);
    int dl;
    logic [11:0] r;
    dl = 5 + f[3:2];
    r = '0;
    for (int i = 0; i < dl; i++) r[i+1] = c[i];
    r[dl+1] = f[1] | (^r ^ !f[0]);
    if (!f[1]) r[dl+2] = 1'b1;
    return r;
  endfunction
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1;
    wb(0, `REG_FORMAT, 0);
    chk("format reset", `FMT_RESET, rdata);
    wb(0, `REG_STATUS, 0);
    chk("status reset", 32'h2, rdata);
    chk("idle line", 1, serial_out);
    wb(0, 8'h40, 0);
    chk("unmapped read", 0, rdata);
    wb(1, `REG_IRQ_ENABLE, 32'h2);
    $display("reset test done");
    for (int r = 0; r < 12; r++) begin
      // Park the line at mark first, so the clear never cuts a bit short.
      stall <= 1;
      repeat (130) @(posedge clk);
      wb(1, `REG_CONTROL, {`BIT_DIV_RESET, 16'h0002});
      stall <= 0;
      nbits <= 4'd8 + {2'b00, fmts[r][3:2]} - {3'b000, fmts[r][1]};
      ch = 8'(165 + 7 * r);
      wb(1, `REG_FORMAT, {26'h0, fmts[r]});
      wb(1, `REG_FILL, 32'h0F ^ r);
      wb(1, `REG_HOLD, {24'h0, ch});
      waitf();
      chk("char frame", frm(fmts[r], ch), frame);
      e = frm(fmts[r], 8'(15 ^ r));
      waitf();
      chk("fill frame", e, frame);
      chk("fill flag", 1, fill_pending_flag);
      $display("row %0d done", r);
    end
    chk("irq raised", 1, irq);
    wb(1, `REG_IRQ_ENABLE, 0);
    settle();
    chk("irq masked", 0, irq);
    wb(1, `REG_IRQ_ENABLE, 32'h2);
    settle();
    chk("irq unmasked", 1, irq);
    wb(1, `REG_IRQ_CLEAR, 32'h2);
    settle();
    chk("irq cleared", 0, irq);
    $display("interrupt test done");
    wb(1, `REG_HOLD, 32'h5A);
    waitf();
    if (frame === e) waitf();
    chk("char after fill", frm(6'h3F, 8'h5A), frame);
    chk("no gap", 1, gap < 8'd10);
    repeat (20) @(posedge clk);
    wb(1, `REG_CONTROL, {`BIT_DIV_RESET, 16'h0001});
    settle();
    chk("fill flag clear", 0, fill_pending_flag);
    $display("contiguity test done");
    @(posedge clk) stall <= 1;
    wb(1, `REG_HOLD, 32'hC3);
    repeat (150) @(posedge clk);
    n = 0;
    repeat (200) begin @(posedge clk); n += !serial_out; end
    chk("mark while stalled", 0, n);
    chk("hold kept", 0, hold_empty_flag);
    stall <= 0;
    waitf();
    chk("char on release", frm(6'h3F, 8'hC3), frame);
    $display("flow control test done");
    @(posedge clk) chip_off <= 1;
    // The pin passes two flip-flops before it gates the bus.
    repeat (3) @(posedge clk);
    wb(1, `REG_HOLD, 32'h77);
    settle();
    chk("flags float", 2'b11, {fill_pending_oe_n, hold_empty_oe_n});
    chk("write ignored", 1, hold_empty_flag);
    @(posedge clk) chip_off <= 0;
    repeat (8) @(posedge clk);
    chk("flags driven", 2'b00, {fill_pending_oe_n, hold_empty_oe_n});
    $display("chip off test done");
    final_report();
  end
endmodule // iso_tx_bench
